//--- hdl/asx_pkg.sv
// package for the subtract / xor / swap execution datapath
// assumes: one core clock, decoder presents one operation per cycle
package asx_pkg;
	// ------------------------------------------------------------
	// operation codes
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ASX_OP_NONE = 3'h0,
		ASX_OP_FILE_MINUS_ACC = 3'h1,
		ASX_OP_FILE_MINUS_ACC_BORROW = 3'h2,
		ASX_OP_NIBBLE_EXCHANGE = 3'h3,
		ASX_OP_PIN_DIRECTION_LOAD = 3'h4,
		ASX_OP_LITERAL_XOR_ACC = 3'h5,
		ASX_OP_FILE_XOR_ACC = 3'h6
	} asx_op_t;

	// ------------------------------------------------------------
	// operand selectors and reset values
	// ------------------------------------------------------------
	localparam logic [6:0] ASX_FILE_ADDR_MAX = 7'h7f;
	localparam logic [6:0] ASX_SEL_PORT_A = 7'h05;
	localparam logic [6:0] ASX_SEL_PORT_B = 7'h06;
	localparam logic [6:0] ASX_SEL_PORT_C = 7'h07;
	localparam logic ASX_DEST_ACC = 1'b0;
	localparam logic ASX_DEST_FILE = 1'b1;
	localparam logic [7:0] ASX_ACC_RESET = 8'h00;
	localparam logic [7:0] ASX_DIR_RESET = 8'hff;
	localparam logic [2:0] ASX_FLAGS_RESET = 3'h0;

	// one operation from the decoder
	typedef struct packed {
		logic valid;
		asx_op_t op;
		logic [6:0] addr;
		logic dest;
		logic [7:0] literal;
		logic [7:0] file_data;
	} asx_req_t;

	// status flags
	typedef struct packed {
		logic zero;
		logic nibble_borrow_flag;
		logic carry;
	} asx_flags_t;

	// combinational result of the unit
	typedef struct packed {
		logic [7:0] value;
		asx_flags_t flags;
		logic wr_acc;
		logic wr_file;
		logic [2:0] wr_dir;
	} asx_res_t;
endpackage

//--- hdl/asx_alu.sv
// combinational arithmetic for the datapath
// assumes: operands settled within the cycle; flags fed back from the top
`timescale 1ns/100ps
`default_nettype none
module asx_alu (
	// operation in
	input wire asx_pkg::asx_req_t req,
	input wire logic [7:0] acc,
	input wire asx_pkg::asx_flags_t flags_in,
	// result out
	output var asx_pkg::asx_res_t res
);
	logic [8:0] diff;
	logic [4:0] low_diff;
	logic borrow_in;

	// ------------------------------------------------------------
	// subtract core
	// ------------------------------------------------------------
	// file - acc - borrow; carry out is no-borrow
	always_comb begin
		borrow_in = (req.op == asx_pkg::ASX_OP_FILE_MINUS_ACC_BORROW) && !flags_in.carry;
		diff = {1'b0, req.file_data} + {1'b0, ~acc} + {8'h00, !borrow_in};
		low_diff = {1'b0, req.file_data[3:0]} + {1'b0, ~acc[3:0]} + {4'h0, !borrow_in};
	end

	// ------------------------------------------------------------
	// result select
	// ------------------------------------------------------------
	always_comb begin
		res = '0;
		res.flags = flags_in;
		case (req.op)
			asx_pkg::ASX_OP_FILE_MINUS_ACC,
			asx_pkg::ASX_OP_FILE_MINUS_ACC_BORROW: begin
				res.value = diff[7:0];
				res.flags.carry = diff[8];
				res.flags.nibble_borrow_flag = low_diff[4];
				res.flags.zero = (diff[7:0] == 8'h00);
			end
			asx_pkg::ASX_OP_NIBBLE_EXCHANGE: begin
				res.value = {req.file_data[3:0], req.file_data[7:4]};
			end
			asx_pkg::ASX_OP_LITERAL_XOR_ACC: begin
				res.value = acc ^ req.literal;
				res.flags.zero = (res.value == 8'h00);
			end
			asx_pkg::ASX_OP_FILE_XOR_ACC: begin
				res.value = acc ^ req.file_data;
				res.flags.zero = (res.value == 8'h00);
			end
			asx_pkg::ASX_OP_PIN_DIRECTION_LOAD: begin
				res.value = acc;
			end
			default: begin
				res.value = 8'h00;
			end
		endcase
		if (req.valid) begin
			case (req.op)
				asx_pkg::ASX_OP_LITERAL_XOR_ACC: res.wr_acc = 1'b1;
				asx_pkg::ASX_OP_FILE_MINUS_ACC,
				asx_pkg::ASX_OP_FILE_MINUS_ACC_BORROW,
				asx_pkg::ASX_OP_NIBBLE_EXCHANGE,
				asx_pkg::ASX_OP_FILE_XOR_ACC: begin
					res.wr_acc = (req.dest == asx_pkg::ASX_DEST_ACC);
					res.wr_file = (req.dest == asx_pkg::ASX_DEST_FILE);
				end
				asx_pkg::ASX_OP_PIN_DIRECTION_LOAD: begin
					res.wr_dir[0] = (req.addr == asx_pkg::ASX_SEL_PORT_A);
					res.wr_dir[1] = (req.addr == asx_pkg::ASX_SEL_PORT_B);
					res.wr_dir[2] = (req.addr == asx_pkg::ASX_SEL_PORT_C);
				end
				default: res.wr_acc = 1'b0;
			endcase
		end
		if (!req.valid || req.op == asx_pkg::ASX_OP_NONE ||
			req.op == asx_pkg::ASX_OP_NIBBLE_EXCHANGE ||
			req.op == asx_pkg::ASX_OP_PIN_DIRECTION_LOAD) begin
			res.flags = flags_in;
		end
	end
endmodule // asx_alu
`default_nettype wire

//--- hdl/asx_top.sv
// top of the subtract / xor / swap execution datapath
// assumes: decoder supplies file data already read for the given address
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - file-minus-acc gives 8-bit file value minus accumulator, address 0..127
// - destination bit 0 writes accumulator, 1 writes the file register
// - carry cleared when accumulator exceeds file value, else set
// - nibble borrow flag cleared when acc low nibble exceeds file's, else set
// - borrow subtract takes accumulator and inverted carry from file value
// - nibble exchange swaps file nibbles, flags untouched
// - direction load copies accumulator to port A/B/C direction for 5/6/7
// - literal xor writes acc xor literal into accumulator, zero flag only
// - file xor routes acc xor file by destination, zero flag only
module asx_top (
	// clock and reset
	input wire logic REF_CLK,
	input wire logic NRST,
	// operation from decoder
	input wire asx_pkg::asx_req_t REQ,
	// results
	output logic [7:0] ACC,
	output var asx_pkg::asx_flags_t FLAGS,
	output logic FILE_WE,
	output logic [6:0] FILE_ADDR,
	output logic [7:0] FILE_WDATA,
	output logic [7:0] PORT_A_DIRECTION,
	output logic [7:0] PORT_B_DIRECTION,
	output logic [7:0] PORT_C_DIRECTION
);
	logic rst_meta;
	logic rst_n;
	asx_pkg::asx_res_t res;

	// ------------------------------------------------------------
	// reset release
	// ------------------------------------------------------------
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// ------------------------------------------------------------
	// arithmetic
	// ------------------------------------------------------------
	asx_alu u_alu (
		.req(REQ),
		.acc(ACC),
		.flags_in(FLAGS),
		.res(res)
	);

	// accumulator and flags
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			ACC <= asx_pkg::ASX_ACC_RESET;
			FLAGS <= asx_pkg::ASX_FLAGS_RESET;
		end else begin
			if (res.wr_acc) begin
				ACC <= res.value;
			end
			FLAGS <= res.flags;
		end
	end

	// file write-back
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			FILE_WE <= 1'b0;
			FILE_ADDR <= 7'h00;
			FILE_WDATA <= 8'h00;
		end else begin
			FILE_WE <= res.wr_file;
			FILE_ADDR <= REQ.addr;
			FILE_WDATA <= res.value;
		end
	end

	// direction registers
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			PORT_A_DIRECTION <= asx_pkg::ASX_DIR_RESET;
			PORT_B_DIRECTION <= asx_pkg::ASX_DIR_RESET;
			PORT_C_DIRECTION <= asx_pkg::ASX_DIR_RESET;
		end else begin
			if (res.wr_dir[0]) PORT_A_DIRECTION <= res.value;
			if (res.wr_dir[1]) PORT_B_DIRECTION <= res.value;
			if (res.wr_dir[2]) PORT_C_DIRECTION <= res.value;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_sub_result;
		@(posedge REF_CLK) disable iff (!rst_n)
		(REQ.valid && REQ.op == asx_pkg::ASX_OP_FILE_MINUS_ACC && REQ.dest == 1'b0)
		|=> ACC == $past(REQ.file_data) - $past(ACC);
	endproperty
	a_sub_result: assert property (p_sub_result) else $error("subtract result wrong");

	property p_file_dest;
		@(posedge REF_CLK) disable iff (!rst_n)
		(REQ.valid && REQ.op == asx_pkg::ASX_OP_FILE_XOR_ACC && REQ.dest == 1'b1)
		|=> FILE_WE && FILE_WDATA == ($past(ACC) ^ $past(REQ.file_data)) && $stable(ACC);
	endproperty
	a_file_dest: assert property (p_file_dest) else $error("file destination wrong");

	property p_sub_carry;
		@(posedge REF_CLK) disable iff (!rst_n)
		(REQ.valid && REQ.op == asx_pkg::ASX_OP_FILE_MINUS_ACC)
		|=> FLAGS.carry == ($past(ACC) <= $past(REQ.file_data));
	endproperty
	a_sub_carry: assert property (p_sub_carry) else $error("carry wrong");

	property p_sub_dc;
		@(posedge REF_CLK) disable iff (!rst_n)
		(REQ.valid && REQ.op == asx_pkg::ASX_OP_FILE_MINUS_ACC)
		|=> FLAGS.nibble_borrow_flag == ($past(ACC[3:0]) <= $past(REQ.file_data[3:0]));
	endproperty
	a_sub_dc: assert property (p_sub_dc) else $error("nibble borrow wrong");

	property p_borrow_sub;
		@(posedge REF_CLK) disable iff (!rst_n)
		(REQ.valid && REQ.op == asx_pkg::ASX_OP_FILE_MINUS_ACC_BORROW && REQ.dest == 1'b0)
		|=> ACC == $past(REQ.file_data) - $past(ACC) - {7'h00, !$past(FLAGS.carry)};
	endproperty
	a_borrow_sub: assert property (p_borrow_sub) else $error("borrow subtract wrong");

	property p_swap;
		@(posedge REF_CLK) disable iff (!rst_n)
		(REQ.valid && REQ.op == asx_pkg::ASX_OP_NIBBLE_EXCHANGE)
		|=> $stable(FLAGS) && FILE_WDATA == {$past(REQ.file_data[3:0]), $past(REQ.file_data[7:4])};
	endproperty
	a_swap: assert property (p_swap) else $error("swap wrong");

	property p_dir;
		@(posedge REF_CLK) disable iff (!rst_n)
		(REQ.valid && REQ.op == asx_pkg::ASX_OP_PIN_DIRECTION_LOAD && REQ.addr == 7'h06)
		|=> PORT_B_DIRECTION == $past(ACC) && $stable(PORT_A_DIRECTION) && $stable(FLAGS);
	endproperty
	a_dir: assert property (p_dir) else $error("direction load wrong");

	property p_lit_xor;
		@(posedge REF_CLK) disable iff (!rst_n)
		(REQ.valid && REQ.op == asx_pkg::ASX_OP_LITERAL_XOR_ACC)
		|=> ACC == ($past(ACC) ^ $past(REQ.literal)) && FLAGS.zero == (ACC == 8'h00)
			&& FLAGS.carry == $past(FLAGS.carry);
	endproperty
	a_lit_xor: assert property (p_lit_xor) else $error("literal xor wrong");

	property p_xor_flags;
		@(posedge REF_CLK) disable iff (!rst_n)
		(REQ.valid && REQ.op == asx_pkg::ASX_OP_FILE_XOR_ACC)
		|=> FLAGS.nibble_borrow_flag == $past(FLAGS.nibble_borrow_flag)
			&& FLAGS.zero == (($past(ACC) ^ $past(REQ.file_data)) == 8'h00);
	endproperty
	a_xor_flags: assert property (p_xor_flags) else $error("file xor flags wrong");

	property p_zero;
		@(posedge REF_CLK) disable iff (!rst_n)
		(REQ.valid && REQ.op == asx_pkg::ASX_OP_FILE_MINUS_ACC)
		|=> FLAGS.zero == ($past(REQ.file_data) == $past(ACC));
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong");

	property p_borrow_carry;
		@(posedge REF_CLK) disable iff (!rst_n)
		(REQ.valid && REQ.op == asx_pkg::ASX_OP_FILE_MINUS_ACC_BORROW && FLAGS.carry
			&& REQ.dest == 1'b0)
		|=> ACC == $past(REQ.file_data) - $past(ACC);
	endproperty
	a_borrow_carry: assert property (p_borrow_carry) else $error("no-borrow case wrong");

	// subtract sent back to the file goes out on the write port only
	property p_sub_file;
		@(posedge REF_CLK) disable iff (!rst_n)
		(REQ.valid && REQ.op == asx_pkg::ASX_OP_FILE_MINUS_ACC
			&& REQ.dest == asx_pkg::ASX_DEST_FILE)
		|=> FILE_WE && FILE_ADDR == $past(REQ.addr) && $stable(ACC)
			&& FILE_WDATA == ($past(REQ.file_data) - $past(ACC));
	endproperty
	a_sub_file: assert property (p_sub_file) else $error("subtract write-back wrong");

	// a file operation aimed at the accumulator must not touch data memory
	property p_dest_acc;
		@(posedge REF_CLK) disable iff (!rst_n)
		(REQ.valid && REQ.dest == asx_pkg::ASX_DEST_ACC
			&& (REQ.op == asx_pkg::ASX_OP_FILE_MINUS_ACC
			|| REQ.op == asx_pkg::ASX_OP_FILE_MINUS_ACC_BORROW
			|| REQ.op == asx_pkg::ASX_OP_NIBBLE_EXCHANGE
			|| REQ.op == asx_pkg::ASX_OP_FILE_XOR_ACC))
		|=> !FILE_WE;
	endproperty
	a_dest_acc: assert property (p_dest_acc) else $error("stray file write");

	// idle or empty cycles leave accumulator, flags and direction registers alone and raise no file write
	property p_idle;
		@(posedge REF_CLK) disable iff (!rst_n)
		(!REQ.valid || REQ.op == asx_pkg::ASX_OP_NONE)
		|=> !FILE_WE && $stable(ACC) && $stable(FLAGS) && $stable(PORT_A_DIRECTION)
			&& $stable(PORT_B_DIRECTION) && $stable(PORT_C_DIRECTION);
	endproperty
	a_idle: assert property (p_idle) else $error("idle cycle changed state");

	// borrow subtract: carry and nibble flag include the incoming borrow
	property p_borrow_flags;
		@(posedge REF_CLK) disable iff (!rst_n)
		(REQ.valid && REQ.op == asx_pkg::ASX_OP_FILE_MINUS_ACC_BORROW)
		|=> FLAGS.carry == ({1'b0, $past(REQ.file_data)}
			>= ({1'b0, $past(ACC)} + {8'h00, !$past(FLAGS.carry)}))
			&& FLAGS.nibble_borrow_flag == ({1'b0, $past(REQ.file_data[3:0])}
			>= ({1'b0, $past(ACC[3:0])} + {4'h0, !$past(FLAGS.carry)}));
	endproperty
	a_borrow_flags: assert property (p_borrow_flags) else $error("borrow flags wrong");

	// borrow subtract zero flag follows the 8-bit result
	property p_borrow_zero;
		@(posedge REF_CLK) disable iff (!rst_n)
		(REQ.valid && REQ.op == asx_pkg::ASX_OP_FILE_MINUS_ACC_BORROW)
		|=> FLAGS.zero == (($past(REQ.file_data) - $past(ACC)
			- {7'h00, !$past(FLAGS.carry)}) == 8'h00);
	endproperty
	a_borrow_zero: assert property (p_borrow_zero) else $error("borrow zero wrong");

	// first selector loads port A only
	property p_dir_a;
		@(posedge REF_CLK) disable iff (!rst_n)
		(REQ.valid && REQ.op == asx_pkg::ASX_OP_PIN_DIRECTION_LOAD
			&& REQ.addr == asx_pkg::ASX_SEL_PORT_A)
		|=> PORT_A_DIRECTION == $past(ACC) && $stable(PORT_B_DIRECTION)
			&& $stable(PORT_C_DIRECTION);
	endproperty
	a_dir_a: assert property (p_dir_a) else $error("port a direction load wrong");

	// last selector loads port C only
	property p_dir_c;
		@(posedge REF_CLK) disable iff (!rst_n)
		(REQ.valid && REQ.op == asx_pkg::ASX_OP_PIN_DIRECTION_LOAD
			&& REQ.addr == asx_pkg::ASX_SEL_PORT_C)
		|=> PORT_C_DIRECTION == $past(ACC) && $stable(PORT_A_DIRECTION)
			&& $stable(PORT_B_DIRECTION);
	endproperty
	a_dir_c: assert property (p_dir_c) else $error("port c direction load wrong");

	// selectors outside the port range change nothing
	property p_dir_other;
		@(posedge REF_CLK) disable iff (!rst_n)
		(REQ.valid && REQ.op == asx_pkg::ASX_OP_PIN_DIRECTION_LOAD
			&& (REQ.addr < asx_pkg::ASX_SEL_PORT_A || REQ.addr > asx_pkg::ASX_SEL_PORT_C))
		|=> $stable(PORT_A_DIRECTION) && $stable(PORT_B_DIRECTION)
			&& $stable(PORT_C_DIRECTION) && $stable(ACC) && $stable(FLAGS);
	endproperty
	a_dir_other: assert property (p_dir_other) else $error("stray direction load");
endmodule // asx_top
`default_nettype wire

//--- verification/asx_mem_model.sv
// data memory model on the far side of the datapath
// assumes: combinational read, write-back on rising edge
`timescale 1ns/100ps
`default_nettype none
module asx_mem_model (
	// clock
	input wire logic clk,
	// read side
	input wire logic [6:0] raddr,
	output logic [7:0] rdata,
	// write-back side
	input wire logic we,
	input wire logic [6:0] waddr,
	input wire logic [7:0] wdata
);
	logic [7:0] mem [128];
	// known starting pattern
	initial begin
		for (int i = 0; i < 128; i++) begin
			mem[i] = 8'(i) ^ 8'h3c;
		end
	end
	// read is immediate, like a register file
	assign rdata = mem[raddr];
	// take write-back from the datapath
	always @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end
endmodule // asx_mem_model
`default_nettype wire

//--- verification/tb_asx_top.sv
// testbench for the subtract / xor / swap datapath
// assumes: memory model feeds file data; expectations kept here
`timescale 1ns/100ps
`default_nettype none
module tb_asx_top;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic r_valid = 1'b0;
	asx_pkg::asx_op_t r_op = asx_pkg::ASX_OP_NONE;
	logic [6:0] r_addr = 7'h00;
	logic r_dest = 1'b0;
	logic [7:0] r_lit = 8'h00;
	logic [7:0] rdata, acc, pa, pb, pc, wdata;
	asx_pkg::asx_req_t req;
	asx_pkg::asx_flags_t flags;
	logic we;
	logic [6:0] waddr;
	int failures = 0;
	int num_checks = 0;
	logic [7:0] e_acc = 8'h00;
	logic [7:0] e_dir [3] = '{8'hff, 8'hff, 8'hff};
	logic [2:0] e_fl = 3'h0;
	logic [7:0] em [128];
	// clock, request assembly
	always #2.5 clk = ~clk;
	always_comb req = '{r_valid, r_op, r_addr, r_dest, r_lit, rdata};
	asx_top u_asx_top (.REF_CLK(clk), .NRST(nrst), .REQ(req), .ACC(acc), .FLAGS(flags),
		.FILE_WE(we), .FILE_ADDR(waddr), .FILE_WDATA(wdata), .PORT_A_DIRECTION(pa),
		.PORT_B_DIRECTION(pb), .PORT_C_DIRECTION(pc));
	asx_mem_model u_asx_mem_model (.clk(clk), .raddr(r_addr), .rdata(rdata), .we(we),
		.waddr(waddr), .wdata(wdata));
	// compare one value
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask
	// compare every output against the expectations, file data and address only when a file write is expected
	task automatic chk_all(input logic [7:0] r, input logic wf, input logic [6:0] a);
		chk(acc, e_acc, "acc");
		chk({5'h00, flags}, {5'h00, e_fl}, "flags");
		chk({7'h00, we}, {7'h00, wf}, "file write");
		if (wf) chk(wdata, r, "file data");
		if (wf) chk({1'b0, waddr}, {1'b0, a}, "file addr");
		chk(pa, e_dir[0], "dir a");
		chk(pb, e_dir[1], "dir b");
		chk(pc, e_dir[2], "dir c");
	endtask
	// one operation: predict, drive for one cycle, compare
	task automatic do_op(input asx_pkg::asx_op_t op, input logic [6:0] a, input logic d,
		input logic [7:0] k);
		logic [7:0] fv, r;
		logic [8:0] dif;
		logic [4:0] nib;
		logic bin, wr;
		fv = em[a];
		bin = ~e_fl[0];
		r = 8'h00;
		wr = op inside {asx_pkg::ASX_OP_FILE_MINUS_ACC, asx_pkg::ASX_OP_FILE_MINUS_ACC_BORROW,
			asx_pkg::ASX_OP_NIBBLE_EXCHANGE, asx_pkg::ASX_OP_FILE_XOR_ACC};
		if (op == asx_pkg::ASX_OP_FILE_MINUS_ACC) bin = 1'b0;
		case (op)
			asx_pkg::ASX_OP_FILE_MINUS_ACC, asx_pkg::ASX_OP_FILE_MINUS_ACC_BORROW: begin
				dif = {1'b0, fv} - {1'b0, e_acc} - 9'(bin);
				nib = {1'b0, fv[3:0]} - {1'b0, e_acc[3:0]} - 5'(bin);
				r = dif[7:0];
				e_fl = {r == 8'h00, ~nib[4], ~dif[8]};
			end
			asx_pkg::ASX_OP_NIBBLE_EXCHANGE: r = {fv[3:0], fv[7:4]};
			asx_pkg::ASX_OP_PIN_DIRECTION_LOAD: begin
				if (a >= 7'h05 && a <= 7'h07) e_dir[a - 7'h05] = e_acc;
			end
			asx_pkg::ASX_OP_LITERAL_XOR_ACC: r = e_acc ^ k;
			asx_pkg::ASX_OP_FILE_XOR_ACC: r = e_acc ^ fv;
			default: r = 8'h00;
		endcase
		if (op inside {asx_pkg::ASX_OP_LITERAL_XOR_ACC, asx_pkg::ASX_OP_FILE_XOR_ACC})
			e_fl[2] = (r == 8'h00);
		if (op == asx_pkg::ASX_OP_LITERAL_XOR_ACC || (wr && !d)) e_acc = r;
		if (wr && d) em[a] = r;
		@(posedge clk);
		r_valid <= 1'b1;
		r_op <= op;
		r_addr <= a;
		r_dest <= d;
		r_lit <= k;
		@(posedge clk);
		r_valid <= 1'b0;
		#1;
		chk_all(r, wr && d, a);
	endtask
	// load the accumulator through literal xor
	task automatic set_acc(input logic [7:0] v);
		do_op(asx_pkg::ASX_OP_LITERAL_XOR_ACC, 7'h00, 1'b0, e_acc ^ v);
	endtask
	// subtract: equal, borrow out, nibble boundary, both destinations
	task automatic t_sub();
		set_acc(8'h3c);
		do_op(asx_pkg::ASX_OP_FILE_MINUS_ACC, 7'h00, 1'b0, 8'h00);
		set_acc(8'h44);
		do_op(asx_pkg::ASX_OP_FILE_MINUS_ACC, 7'h7f, 1'b1, 8'h00);
		do_op(asx_pkg::ASX_OP_FILE_MINUS_ACC, 7'h7f, 1'b0, 8'h00);
		$display("test sub done");
	endtask
	// borrow subtract with carry clear and set
	task automatic t_borrow();
		do_op(asx_pkg::ASX_OP_FILE_MINUS_ACC_BORROW, 7'h01, 1'b0, 8'h00);
		do_op(asx_pkg::ASX_OP_FILE_MINUS_ACC_BORROW, 7'h01, 1'b1, 8'h00);
		set_acc(8'h0d);
		do_op(asx_pkg::ASX_OP_FILE_MINUS_ACC_BORROW, 7'h01, 1'b0, 8'h00);
		do_op(asx_pkg::ASX_OP_FILE_MINUS_ACC_BORROW, 7'h0d, 1'b0, 8'h00);
		$display("test borrow done");
	endtask
	// swap keeps flags, direction load and refused selectors
	task automatic t_swap_dir();
		do_op(asx_pkg::ASX_OP_NIBBLE_EXCHANGE, 7'h02, 1'b0, 8'h00);
		do_op(asx_pkg::ASX_OP_NIBBLE_EXCHANGE, 7'h03, 1'b1, 8'h00);
		for (int i = 4; i < 9; i++) begin
			set_acc(8'(i * 17));
			do_op(asx_pkg::ASX_OP_PIN_DIRECTION_LOAD, 7'(i), 1'b0, 8'h00);
		end
		$display("test swap dir done");
	endtask
	// xor forms and an empty operation
	task automatic t_xor();
		set_acc(8'h5a);
		do_op(asx_pkg::ASX_OP_LITERAL_XOR_ACC, 7'h00, 1'b0, 8'h5a);
		do_op(asx_pkg::ASX_OP_LITERAL_XOR_ACC, 7'h00, 1'b0, 8'hff);
		do_op(asx_pkg::ASX_OP_FILE_XOR_ACC, 7'h04, 1'b1, 8'h00);
		do_op(asx_pkg::ASX_OP_FILE_XOR_ACC, 7'h04, 1'b0, 8'h00);
		do_op(asx_pkg::ASX_OP_NONE, 7'h04, 1'b1, 8'h00);
		$display("test xor done");
	endtask
	// verdict and end of run
	task automatic test_done();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// main sequence
	initial begin
		for (int i = 0; i < 128; i++) begin
			em[i] = 8'(i) ^ 8'h3c;
		end
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		repeat (4) @(posedge clk);
		#1;
		chk_all(8'h00, 1'b0, 7'h00);
		$display("test reset done");
		t_sub();
		t_borrow();
		t_swap_dir();
		t_xor();
		test_done();
	end
	// watchdog, far beyond the 64 or so cycles needed
	initial begin
		#20000;
		failures++;
		test_done();
	end
endmodule // tb_asx_top
`default_nettype wire
